// *** hw/rpcd_decoder.sv ***
// Row packet command decoder: device match, activate and row opcode decode,
// refresh row counter and power state, with AHB-Lite control and status.
// Assumes packet fields arrive in parallel, synchronous to ref_clk_i, once per cycle.
//
// Operation
// - Both framing bits set: broadcast, device_hit asserted regardless of own number.
// - One framing bit: hit when own number equals {frame-derived top bit, low field}.
// - No framing bit: no packet, no hit, no command.
// - Activate or opcode commands execute only with device_hit asserted.
// - Kind bit 1: open row_field in addressed bank, enter attention state.
// - Kind bit 0: remaining bits form the 11-bit row opcode for the bank.
// - Bits 10..6 = 11000, low 000: close the addressed bank.
// - Bits 10..4 = 0001100: open refresh counter row, bump counter on last bank.
// - Bits 10..4 = 1010100: refresh close, same as a bank close.
// - Bits 8..4 = 00001, low 000: enter powerdown state.
// - Bits 8..4 = 00010, low 000: enter nap state.
// - Bits 8..4 = 00011, low 000: enter nap conditionally.
// - Bit 3 = 0, low 000, bits 10..4 not all zero: enter attention state.
// - Bit 3 = 1, low 000: enter standby state.
// - Upper bits zero, low 001: start temperature calibration.
// - Upper bits zero, low 010: temperature calibrate and enable slew control.
// - Broadcast attention does not move standby to attention.
// - Merged opcodes execute every command they encode together.
// - Reserved bank and row bits are ignored in decode.
`timescale 1ns/1ps

module rpcd_decoder
    import rpcd_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic rst_i,
    // Row packet fields
    input wire logic select_hi_frame_i,
    input wire logic select_lo_frame_i,
    input wire logic [DEVLO_W-1:0] device_low_field_i,
    input wire logic [BANK_W-1:0] bank_field_i,
    input wire logic row_kind_bit_i,
    input wire logic [OP_W-1:0] row_payload_i,
    // Decoded commands
    output logic device_hit_o,
    output logic row_open_o,
    output logic bank_close_o,
    output logic refresh_open_o,
    output logic refresh_close_o,
    output logic temp_calibrate_o,
    output logic temp_cal_enable_o,
    output logic [BANK_W-1:0] cmd_bank_o,
    output logic [ROW_W-1:0] cmd_row_o,
    output logic [1:0] power_state_o,
    // AHB-Lite slave
    input wire logic hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [2:0] hsize_i,
    input wire logic [31:0] hwdata_i,
    input wire logic hready_i,
    output logic [31:0] hrdata_o,
    output logic hreadyout_o,
    output logic hresp_o
);

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    rpcd_state_s st;
    rpcd_state_s nxt;

    logic bcast;
    logic hit;
    logic [OP_W-1:0] op;
    logic is_row;
    logic do_close;
    logic do_ref_open;
    logic do_ref_close;
    logic do_temp_calibrate;
    logic do_temp_cal_enable;
    logic bus_go;
    logic [7:0] raddr;

    // ----------------------------------------------------------------
    // Device match and opcode decode
    // ----------------------------------------------------------------
    assign bcast = select_hi_frame_i && select_lo_frame_i;
    assign op = row_payload_i;
    // Of the low-000 opcodes only the all-zero one is the no-operation code; bit 3 alone still means standby
    assign is_row = (op[2:0] == SUB_ROW) && (op[10:3] != '0);

    always_comb
    begin
        hit = 1'b0;
        if (bcast)
        begin
            hit = 1'b1;
        end
        else if (select_lo_frame_i)
        begin
            hit = (st.own_dev == {1'b0, device_low_field_i});
        end
        else if (select_hi_frame_i)
        begin
            hit = (st.own_dev == {1'b1, device_low_field_i});
        end
    end

    // Each command decodes separately so merged opcodes fire together
    assign do_close = is_row && (op[10:6] == OP_CLOSE_HI);
    assign do_ref_open = is_row && (op[10:4] == OP_REF_OPEN);
    assign do_ref_close = is_row && (op[10:4] == OP_REF_CLOSE);
    assign do_temp_calibrate = (op[10:4] == OP_UPPER_ZERO) && (op[2:0] == SUB_TEMP_CALIBRATE);
    assign do_temp_cal_enable = (op[10:4] == OP_UPPER_ZERO) && (op[2:0] == SUB_TEMP_CAL_ENABLE);

    assign bus_go = hsel_i && hready_i && (htrans_i == HTRANS_NONSEQ);
    assign raddr = haddr_i[7:0];

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb
    begin
        nxt = st;
        nxt.hit = hit;
        nxt.row_open = 1'b0;
        nxt.bank_close = 1'b0;
        nxt.ref_open = 1'b0;
        nxt.ref_close = 1'b0;
        nxt.temp_calibrate = 1'b0;
        nxt.temp_cal_enable = 1'b0;
        nxt.rdy = 1'b1;

        if (hit)
        begin
            if (row_kind_bit_i)
            begin
                nxt.row_open = 1'b1;
                nxt.bank = bank_field_i;
                nxt.row = op[ROW_W-1:0];
                nxt.ps = PS_ATTENTION;
            end
            else
            begin
                if (do_close || do_ref_close)
                begin
                    nxt.bank_close = do_close;
                    nxt.ref_close = do_ref_close;
                    nxt.bank = bank_field_i;
                end
                if (do_ref_open)
                begin
                    nxt.ref_open = 1'b1;
                    nxt.bank = bank_field_i;
                    nxt.row = st.ref_row;
                    if (bank_field_i == BANK_LAST)
                    begin
                        nxt.ref_row = st.ref_row + REF_ROW_STEP;
                    end
                end
                nxt.temp_calibrate = do_temp_calibrate;
                nxt.temp_cal_enable = do_temp_cal_enable;
                if (is_row)
                begin
                    if (op[8:4] == OP_PDN)
                    begin
                        nxt.ps = PS_POWERDOWN;
                    end
                    else if (op[8:4] == OP_NAP)
                    begin
                        nxt.ps = PS_NAP;
                    end
                    else if (op[8:4] == OP_NAP_COND && st.ps == PS_STANDBY)
                    begin
                        nxt.ps = PS_NAP;
                    end
                    else if (op[3])
                    begin
                        nxt.ps = PS_STANDBY;
                    end
                    else if (!(bcast && st.ps == PS_STANDBY))
                    begin
                        nxt.ps = PS_ATTENTION;
                    end
                end
            end
        end

        // Register writes land in the data phase
        if (st.wr_pend && st.wr_addr == REG_CTRL)
        begin
            nxt.own_dev = hwdata_i[DEV_W-1:0];
        end
        nxt.wr_pend = bus_go && hwrite_i;
        nxt.wr_addr = raddr;

        // Read data is taken from the updated state so a write-then-read sees it
        nxt.rdata = RDATA_ZERO;
        if (bus_go && !hwrite_i)
        begin
            case (raddr)
                REG_CTRL:
                begin
                    nxt.rdata[DEV_W-1:0] = nxt.own_dev;
                end
                REG_STATUS:
                begin
                    nxt.rdata[ST_PS_LSB +: 2] = nxt.ps;
                    nxt.rdata[ST_REF_LSB +: ROW_W] = nxt.ref_row;
                    nxt.rdata[ST_BANK_LSB +: BANK_W] = nxt.bank;
                end
                REG_LAST_ROW:
                begin
                    nxt.rdata[ROW_W-1:0] = nxt.row;
                end
                default:
                begin
                    nxt.rdata = RDATA_ZERO;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    always_ff @(posedge ref_clk_i)
    begin
        if (rst_i)
        begin
            st.ps <= PS_STANDBY;
            st.own_dev <= OWN_DEV_RST;
            st.ref_row <= REF_ROW_RST;
            st.hit <= 1'b0;
            st.row_open <= 1'b0;
            st.bank_close <= 1'b0;
            st.ref_open <= 1'b0;
            st.ref_close <= 1'b0;
            st.temp_calibrate <= 1'b0;
            st.temp_cal_enable <= 1'b0;
            st.bank <= '0;
            st.row <= '0;
            st.wr_pend <= 1'b0;
            st.wr_addr <= '0;
            st.rdata <= RDATA_ZERO;
            st.rdy <= 1'b1;
        end
        else
        begin
            st <= nxt;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign device_hit_o = st.hit;
    assign row_open_o = st.row_open;
    assign bank_close_o = st.bank_close;
    assign refresh_open_o = st.ref_open;
    assign refresh_close_o = st.ref_close;
    assign temp_calibrate_o = st.temp_calibrate;
    assign temp_cal_enable_o = st.temp_cal_enable;
    assign cmd_bank_o = st.bank;
    assign cmd_row_o = st.row;
    assign power_state_o = st.ps;
    assign hrdata_o = st.rdata;
    assign hreadyout_o = st.rdy;
    assign hresp_o = 1'b0;

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (rst_i);

    sequence s_op_packet;
        hit && !row_kind_bit_i;
    endsequence

    // Row opcode whose power change is left to bit 3
    sequence s_plain_row;
        is_row && op[8:4] != OP_PDN && op[8:4] != OP_NAP && op[8:4] != OP_NAP_COND;
    endsequence

    sequence s_no_cmd;
        !device_hit_o && !row_open_o && !bank_close_o && !refresh_open_o
            && !refresh_close_o && !temp_calibrate_o && !temp_cal_enable_o;
    endsequence

    a_bcast_hit: assert property (bcast |=> device_hit_o)
        else $error("broadcast packet did not hit");
    a_frame_match: assert property (
        (select_lo_frame_i && !select_hi_frame_i)
        |=> device_hit_o == ($past(st.own_dev) == {1'b0, $past(device_low_field_i)}))
        else $error("low frame match wrong");
    a_hi_frame_match: assert property (
        (select_hi_frame_i && !select_lo_frame_i)
        |=> device_hit_o == ($past(st.own_dev) == {1'b1, $past(device_low_field_i)}))
        else $error("high frame match wrong");
    a_no_frame: assert property (
        !select_hi_frame_i && !select_lo_frame_i |=> s_no_cmd ##0 $stable(power_state_o))
        else $error("command without framing");
    a_miss_idle: assert property (
        (select_hi_frame_i || select_lo_frame_i) && !hit
        |=> s_no_cmd ##0 $stable(power_state_o) ##0 $stable(cmd_bank_o))
        else $error("command on device miss");
    a_act_go_attention: assert property (
        hit && row_kind_bit_i
        |=> row_open_o && power_state_o == PS_ATTENTION
            && cmd_row_o == $past(row_payload_i[ROW_W-1:0]))
        else $error("activate not executed");
    a_bank_close: assert property (
        s_op_packet ##0 do_close |=> bank_close_o && cmd_bank_o == $past(bank_field_i))
        else $error("bank close missing");
    a_ref_step: assert property (
        s_op_packet ##0 do_ref_open && bank_field_i == BANK_LAST
        |=> refresh_open_o && st.ref_row == $past(st.ref_row) + REF_ROW_STEP)
        else $error("refresh counter not stepped");
    a_ref_close: assert property (
        s_op_packet ##0 do_ref_close
        |=> refresh_close_o && cmd_bank_o == $past(bank_field_i))
        else $error("refresh close missing");
    a_pdn_enter: assert property (
        s_op_packet ##0 is_row && op[8:4] == OP_PDN |=> power_state_o == PS_POWERDOWN)
        else $error("powerdown not entered");
    a_nap_enter: assert property (
        s_op_packet ##0 is_row && op[8:4] == OP_NAP |=> power_state_o == PS_NAP)
        else $error("nap not entered");
    a_nap_cond: assert property (
        s_op_packet ##0 is_row && op[8:4] == OP_NAP_COND && st.ps == PS_STANDBY
        |=> power_state_o == PS_NAP)
        else $error("conditional nap not entered");
    a_go_attention_enter: assert property (
        s_op_packet ##0 s_plain_row ##0 !op[3] && !(bcast && st.ps == PS_STANDBY)
        |=> power_state_o == PS_ATTENTION)
        else $error("attention not entered");
    a_standby_enter: assert property (
        s_op_packet ##0 s_plain_row ##0 op[3] |=> power_state_o == PS_STANDBY)
        else $error("standby not entered");
    a_bcast_relax: assert property (
        s_op_packet ##0 s_plain_row ##0 bcast && !op[3] && st.ps == PS_STANDBY
        |=> power_state_o == PS_STANDBY)
        else $error("broadcast woke standby device");
    a_temp_calibrate_pulse: assert property (
        s_op_packet ##0 do_temp_calibrate
        |=> temp_calibrate_o ##1 (!temp_calibrate_o || $past(hit && do_temp_calibrate)))
        else $error("calibration pulse wrong");
    a_temp_cal_enable_pulse: assert property (
        s_op_packet ##0 do_temp_cal_enable |=> temp_cal_enable_o)
        else $error("calibrate enable pulse missing");
    a_nop_hold: assert property (
        s_op_packet ##0 !is_row && !do_temp_calibrate && !do_temp_cal_enable
        |=> $stable(power_state_o) && $stable(st.ref_row) && !bank_close_o)
        else $error("unlisted opcode changed state");

endmodule

// *** inc/rpcd_pkg.sv ***
// Constants, field layouts and types for the row packet command decoder.
// Assumes one 125 MHz clock and an AHB-Lite register bus with 32-bit data.
package rpcd_pkg;

    // ----------------------------------------------------------------
    // Packet field widths
    // ----------------------------------------------------------------
    localparam int DEV_W = 5;
    localparam int DEVLO_W = 4;
    localparam int BANK_W = 5;
    localparam int ROW_W = 9;
    localparam int OP_W = 11;

    // ----------------------------------------------------------------
    // Row opcode patterns
    // ----------------------------------------------------------------
    localparam logic [4:0] OP_CLOSE_HI = 5'h18;      // bits 10..6
    localparam logic [6:0] OP_REF_OPEN = 7'h0C;      // bits 10..4
    localparam logic [6:0] OP_REF_CLOSE = 7'h54;     // bits 10..4
    localparam logic [6:0] OP_UPPER_ZERO = 7'h00;    // bits 10..4
    localparam logic [4:0] OP_PDN = 5'h01;           // bits 8..4
    localparam logic [4:0] OP_NAP = 5'h02;           // bits 8..4
    localparam logic [4:0] OP_NAP_COND = 5'h03;      // bits 8..4
    localparam logic [2:0] SUB_ROW = 3'h0;
    localparam logic [2:0] SUB_TEMP_CALIBRATE = 3'h1;
    localparam logic [2:0] SUB_TEMP_CAL_ENABLE = 3'h2;
    localparam logic [BANK_W-1:0] BANK_LAST = 5'h1F;
    localparam logic [ROW_W-1:0] REF_ROW_RST = 9'h000;
    localparam logic [ROW_W-1:0] REF_ROW_STEP = 9'h001;

    // ----------------------------------------------------------------
    // Register map (byte addresses) and field positions
    // ----------------------------------------------------------------
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_LAST_ROW = 8'h08;
    localparam int ST_PS_LSB = 0;
    localparam int ST_REF_LSB = 4;
    localparam int ST_BANK_LSB = 16;
    localparam logic [DEV_W-1:0] OWN_DEV_RST = 5'h00;
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [31:0] RDATA_ZERO = 32'h0000_0000;

    // ----------------------------------------------------------------
    // Types
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        PS_STANDBY,
        PS_ATTENTION,
        PS_NAP,
        PS_POWERDOWN
    } rpcd_power_e;

    typedef struct packed {
        rpcd_power_e ps;
        logic [DEV_W-1:0] own_dev;
        logic [ROW_W-1:0] ref_row;
        logic hit;
        logic row_open;
        logic bank_close;
        logic ref_open;
        logic ref_close;
        logic temp_calibrate;
        logic temp_cal_enable;
        logic [BANK_W-1:0] bank;
        logic [ROW_W-1:0] row;
        logic wr_pend;
        logic [7:0] wr_addr;
        logic [31:0] rdata;
        logic rdy;
    } rpcd_state_s;

endpackage

// *** dv/rpcd_ctrl_model.sv ***
// Channel controller model: puts one row packet on the fields per call.
// Assumes the bench calls send from one process, in step with ref_clk_i.
`timescale 1ns/1ps

module rpcd_ctrl_model
    import rpcd_pkg::*;
(
    // Clock
    input wire logic ref_clk_i,
    // Row packet fields
    output logic select_hi_frame_o,
    output logic select_lo_frame_o,
    output logic [DEVLO_W-1:0] device_low_field_o,
    output logic [BANK_W-1:0] bank_field_o,
    output logic row_kind_bit_o,
    output logic [OP_W-1:0] row_payload_o
);
    initial
    begin
        select_hi_frame_o = 1'b0;
        select_lo_frame_o = 1'b0;
        device_low_field_o = 4'h0;
        bank_field_o = 5'h00;
        row_kind_bit_o = 1'b0;
        row_payload_o = 11'h000;
    end

    // Merged opcodes are passed through whole
    task automatic send(input logic hi, input logic lo, input logic [3:0] d,
        input logic [4:0] b, input logic k, input logic [10:0] p);
        @(posedge ref_clk_i);
        select_hi_frame_o <= hi;
        select_lo_frame_o <= lo;
        device_low_field_o <= d;
        bank_field_o <= b;
        row_kind_bit_o <= k;
        row_payload_o <= p;
        @(posedge ref_clk_i);
        // Unframed fields carry the inverse so stale values are never trusted
        select_hi_frame_o <= 1'b0;
        select_lo_frame_o <= 1'b0;
        device_low_field_o <= ~d;
        bank_field_o <= ~b;
        row_kind_bit_o <= ~k;
        row_payload_o <= ~p;
    endtask
endmodule

// *** dv/tb.sv ***
// Self-checking bench for the row packet command decoder.
// Assumes the controller model in rpcd_ctrl_model and zero-wait AHB-Lite.
`timescale 1ns/1ps

module tb
    import rpcd_pkg::*;
;
    logic ref_clk_i, rst_i, hsel, hwrite, fr_hi, fr_lo, kind_w;
    logic [3:0] dev_w;
    logic [4:0] bank_w;
    logic [10:0] pay_w;
    logic [31:0] haddr, hwdata, rd, seed;
    logic [1:0] htrans, ps_e;
    logic [2:0] hsize;
    logic [8:0] ref_e;
    logic [4:0] own;
    logic device_hit_o, row_open_o, bank_close_o, refresh_open_o, refresh_close_o;
    logic temp_calibrate_o, temp_cal_enable_o, hreadyout_o, hresp_o;
    logic [4:0] cmd_bank_o;
    logic [8:0] cmd_row_o;
    logic [1:0] power_state_o;
    logic [31:0] hrdata_o;
    int error_cnt, num_checks;

    rpcd_ctrl_model u_ctrl (.ref_clk_i(ref_clk_i), .select_hi_frame_o(fr_hi),
        .select_lo_frame_o(fr_lo), .device_low_field_o(dev_w), .bank_field_o(bank_w),
        .row_kind_bit_o(kind_w), .row_payload_o(pay_w));

    rpcd_decoder u_dut (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .select_hi_frame_i(fr_hi),
        .select_lo_frame_i(fr_lo), .device_low_field_i(dev_w), .bank_field_i(bank_w),
        .row_kind_bit_i(kind_w), .row_payload_i(pay_w), .device_hit_o(device_hit_o),
        .row_open_o(row_open_o), .bank_close_o(bank_close_o),
        .refresh_open_o(refresh_open_o), .refresh_close_o(refresh_close_o),
        .temp_calibrate_o(temp_calibrate_o), .temp_cal_enable_o(temp_cal_enable_o),
        .cmd_bank_o(cmd_bank_o), .cmd_row_o(cmd_row_o), .power_state_o(power_state_o),
        .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite),
        .hsize_i(hsize), .hwdata_i(hwdata), .hready_i(hreadyout_o), .hrdata_o(hrdata_o),
        .hreadyout_o(hreadyout_o), .hresp_o(hresp_o));

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    function automatic logic hit_exp(input logic hi, input logic lo, input logic [3:0] d);
        return (hi & lo) | ((hi ^ lo) & (own == {hi, d}));
    endfunction

    function automatic logic [1:0] ps_exp(input logic [10:0] p, input logic [1:0] cur,
        input logic bc);
        if (p[8:4] == 5'h01) return 2'h3;
        if (p[8:4] == 5'h02) return 2'h2;
        if (p[8:4] == 5'h03 && cur == 2'h0) return 2'h2;
        if (p[3]) return 2'h0;
        if (bc && cur == 2'h0) return cur;
        return 2'h1;
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("ERROR t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic report_and_stop();
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        @(posedge ref_clk_i);
        hsel <= 1'b1;
        haddr <= {24'h000000, a};
        hwrite <= wr;
        htrans <= HTRANS_NONSEQ;
        hsize <= 3'h2;
        do @(posedge ref_clk_i); while (hreadyout_o !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge ref_clk_i); while (hreadyout_o !== 1'b1);
        rd = hrdata_o;
        chk(hresp_o, 32'h0000_0000);
    endtask

    task automatic run(input logic hi, input logic lo, input logic [3:0] d,
        input logic [4:0] b, input logic k, input logic [10:0] p);
        logic h, op;
        h = hit_exp(hi, lo, d);
        op = h & !k & (p[2:0] == 3'h0);
        u_ctrl.send(hi, lo, d, b, k, p);
        #1;
        chk(device_hit_o, h);
        chk(row_open_o, h & k);
        chk(bank_close_o, op & (p[10:6] == 5'h18));
        chk(refresh_open_o, op & (p[10:4] == 7'h0C));
        chk(refresh_close_o, op & (p[10:4] == 7'h54));
        chk(temp_calibrate_o, h & !k & ((p & 11'h7F7) == 11'h001));
        chk(temp_cal_enable_o, h & !k & ((p & 11'h7F7) == 11'h002));
        if (op & (p[10:6] == 5'h18 | p[10:4] == 7'h54 | p[10:4] == 7'h0C))
            chk(cmd_bank_o, b);
        if (h & k)
        begin
            chk(cmd_row_o, p[8:0]);
            chk(cmd_bank_o, b);
            ps_e = 2'h1;
        end
        if (op & (p[10:4] == 7'h0C))
        begin
            chk(cmd_row_o, ref_e);
            ref_e = ref_e + {8'h00, b == 5'h1F};
        end
        if (op & (p != 11'h000))
            ps_e = ps_exp(p, ps_e, hi & lo);
        chk(power_state_o, ps_e);
    endtask

    // ----------------------------------------------------------------
    // Clock, watchdog and main sequence
    // ----------------------------------------------------------------
    initial
    begin
        ref_clk_i = 1'b0;
        forever #4 ref_clk_i = ~ref_clk_i;
    end

    initial
    begin
        repeat (4000) @(posedge ref_clk_i);
        error_cnt++;
        report_and_stop();
    end

    initial
    begin
        logic [31:0] r;
        rst_i = 1'b1;
        hsel = 1'b0;
        haddr = 32'h0000_0000;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0000_0000;
        seed = 32'h0000_6432;
        own = 5'h13;
        ps_e = 2'h0;
        ref_e = 9'h000;
        error_cnt = 0;
        num_checks = 0;
        repeat (6) @(posedge ref_clk_i);
        rst_i <= 1'b0;
        #1;
        chk(power_state_o, 32'h0000_0000);
        chk(hreadyout_o, 32'h0000_0001);
        ahb(1'b1, REG_CTRL, {27'h0, own});
        ahb(1'b0, REG_CTRL, 32'h0000_0000);
        chk(rd, {27'h0, own});
        ahb(1'b0, 8'h0C, 32'h0000_0000);
        chk(rd, 32'h0000_0000);
        for (int i = 0; i < 16; i++)
            run(i[0], i[1], (i[3:2] == 2'h0) ? own[3:0] : 4'(xs() >> 28), 5'h04, 1'b1, 11'h1A5);
        run(1'b1, 1'b1, 4'h0, 5'h00, 1'b0, 11'h008);
        run(1'b1, 1'b1, 4'h0, 5'h00, 1'b0, 11'h000);
        run(1'b1, 1'b1, 4'h0, 5'h00, 1'b0, 11'h400);
        run(1'b1, 1'b0, 4'h3, 5'h00, 1'b0, 11'h400);
        run(1'b1, 1'b1, 4'h0, 5'h00, 1'b0, 11'h010);
        run(1'b0, 1'b1, 4'h3, 5'h00, 1'b0, 11'h020);
        run(1'b1, 1'b0, 4'h3, 5'h00, 1'b0, 11'h020);
        run(1'b1, 1'b0, 4'h3, 5'h00, 1'b0, 11'h008);
        run(1'b1, 1'b0, 4'h3, 5'h09, 1'b0, 11'h638);
        run(1'b1, 1'b0, 4'h3, 5'h00, 1'b0, 11'h038);
        run(1'b1, 1'b0, 4'h3, 5'h00, 1'b0, 11'h001);
        run(1'b1, 1'b0, 4'h3, 5'h00, 1'b0, 11'h00A);
        run(1'b1, 1'b0, 4'h3, 5'h00, 1'b0, 11'h081);
        run(1'b1, 1'b0, 4'h3, 5'h00, 1'b0, 11'h003);
        run(1'b1, 1'b0, 4'h3, 5'h0E, 1'b0, 11'h600);
        run(1'b1, 1'b0, 4'h3, 5'h1E, 1'b0, 11'h540);
        run(1'b1, 1'b1, 4'h0, 5'h05, 1'b0, 11'h0C0);
        run(1'b1, 1'b1, 4'h0, 5'h1F, 1'b0, 11'h0C0);
        for (int i = 0; i < 300; i++)
        begin
            r = xs();
            run(r[0], r[1], r[2] ? own[3:0] : r[6:3], r[31:27], r[7],
                {r[18:11], r[20] ? 3'h0 : r[10:8]});
        end
        for (int i = 0; i < 512; i++)
            run(1'b1, 1'b0, 4'h3, 5'h1F, 1'b0, 11'h0C8);
        ahb(1'b0, REG_STATUS, 32'h0000_0000);
        chk(rd, {11'h000, 5'h1F, 3'h0, ref_e, 2'h0, ps_e});
        ahb(1'b0, REG_LAST_ROW, 32'h0000_0000);
        chk(rd, {23'h000000, ref_e - 9'h001});
        report_and_stop();
    end
endmodule
